// ### mft_pkg.sv
`default_nettype none
package mft_pkg;
  localparam int unsigned MFT_WIDTH = 16;
  localparam logic [15:0] MFT_COUNT_RESET = 16'h0000;
  localparam logic [15:0] MFT_COUNT_MAX = 16'hFFFF;
  localparam int unsigned MFT_PRESCALE_WIDTH = 8;
  localparam logic [2:0] MFT_DIV_RESET = 3'h0;
  // exchange select codes for the cpu port-control exchange
  localparam logic [1:0] MFT_SEL_FIRST = 2'h0;
  localparam logic [1:0] MFT_SEL_SECOND = 2'h1;
  localparam logic [1:0] MFT_SEL_CAPTURE = 2'h2;
  // pending flag bit positions
  localparam int unsigned MFT_PEND_OVF = 0;
  localparam int unsigned MFT_PEND_CMP1 = 1;
  localparam int unsigned MFT_PEND_CMP2 = 2;
  localparam int unsigned MFT_PEND_CAP1 = 3;
  localparam int unsigned MFT_PEND_CAP2 = 4;
  localparam int unsigned MFT_PEND_W = 5;

  typedef enum logic [1:0] {
    MFT_MODE_PWM,
    MFT_MODE_SOFT,
    MFT_MODE_EXT,
    MFT_MODE_CAPCMP
  } mft_mode_e;

  // irq enables and input edge choices
  typedef struct packed {
    logic compare_irq_enable;
    logic capture_irq_enable;
    logic overflow_irq_enable;
    logic ext_rising;
    logic cap_rising;
  } mft_cfg_s;

  // cpu exchange request
  typedef struct packed {
    logic req;
    logic [1:0] sel;
    logic [15:0] wdata;
  } mft_xchg_s;
endpackage
`default_nettype wire

// ### mft_prescaler.sv
`default_nettype none
// one-cycle tick every 2**div system clocks, or every 2**WIDTH when div exceeds WIDTH
module mft_prescaler
  import mft_pkg::*;
#(
  parameter int unsigned WIDTH = MFT_PRESCALE_WIDTH
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [$clog2(WIDTH+1)-1:0] div,
  output logic tick
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] mask;

  // mask selects the low div bits; all ones there ends a period
  assign mask = WIDTH'((1 << div) - 1);
  assign tick = ((count & mask) == mask);

  // free-running count; enable pulse rather than divided clock keeps one domain
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= '0;
    else
      count <= count + 1'b1;
  end
endmodule // mft_prescaler
`default_nettype wire

// ### mft_timer.sv
`default_nettype none
module mft_timer
  import mft_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire mft_mode_e mode,
  input wire logic [3:0] div_sel,
  input wire mft_cfg_s cfg,
  input wire logic ext_clk_pin,
  input wire logic capture1_pin,
  input wire logic capture2_pin,
  input wire mft_xchg_s xchg,
  input wire logic [MFT_PEND_W-1:0] pend_clear,
  output logic [15:0] xchg_rdata,
  output logic timer_out,
  output logic [MFT_PEND_W-1:0] pending,
  output logic irq
);
  logic [15:0] count;
  logic [15:0] first_compare_value;
  logic [15:0] second_compare_value;
  logic [15:0] capture_value;
  logic phase_second;
  logic pre_tick;
  logic tick;
  logic [3:0] div_eff;
  logic [2:0] ext_sync;
  logic [2:0] cap1_sync;
  logic [2:0] cap2_sync;
  logic ext_edge;
  logic cap1_edge;
  logic cap2_edge;
  logic [15:0] active_cmp;
  logic match;
  logic overflow;
  logic capcmp;
  logic [MFT_PEND_W-1:0] events;

  // edge of a synchronised pin; the first stage is not looked at
  function automatic logic edge_of(input logic [2:0] s, input logic rising);
    edge_of = rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
  endfunction

  // capture/compare allows only 1..128, so selects above 7 are held to 7 there
  assign capcmp = (mode == MFT_MODE_CAPCMP);
  assign div_eff = (capcmp && div_sel > 4'd7) ? 4'd7 : div_sel;

  mft_prescaler #(
    .WIDTH(MFT_PRESCALE_WIDTH)
  ) u_prescaler (
    .clk(clk),
    .rst(rst),
    .div(div_eff),
    .tick(pre_tick)
  );

  // pins pass two flops before any edge logic reads them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_sync <= '0;
      cap1_sync <= '0;
      cap2_sync <= '0;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], ext_clk_pin};
      cap1_sync <= {cap1_sync[1:0], capture1_pin};
      cap2_sync <= {cap2_sync[1:0], capture2_pin};
    end
  end

  assign ext_edge = edge_of(ext_sync, cfg.ext_rising);
  assign cap1_edge = capcmp & edge_of(cap1_sync, cfg.cap_rising);
  assign cap2_edge = capcmp & edge_of(cap2_sync, cfg.cap_rising);

  // tick source: external pin in event mode, prescaler otherwise
  assign tick = (mode == MFT_MODE_EXT) ? ext_edge : pre_tick;

  // capture/compare always checks the first value; others alternate
  assign active_cmp = (phase_second && !capcmp) ? second_compare_value : first_compare_value;
  assign match = tick && (count == active_cmp);
  assign overflow = tick && (count == MFT_COUNT_MAX) && !(match && !capcmp);

  // counter restarts at zero on a match except in free-running capture/compare
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= MFT_COUNT_RESET;
    else if (match && !capcmp)
      count <= MFT_COUNT_RESET;
    else if (tick)
      count <= count + 16'h0001;
  end

  // phase flips on every match in the alternating modes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      phase_second <= 1'b0;
    else if (match && !capcmp)
      phase_second <= ~phase_second;
  end

  // output toggles on a match in modulation and capture/compare only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timer_out <= 1'b0;
    else if (match && (mode == MFT_MODE_PWM || capcmp))
      timer_out <= ~timer_out;
  end

  // cpu writes the compare values; capture 2 lands in the second value
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_compare_value <= MFT_COUNT_RESET;
      second_compare_value <= MFT_COUNT_RESET;
    end
    else
    begin
      if (xchg.req && xchg.sel == MFT_SEL_FIRST)
        first_compare_value <= xchg.wdata;
      if (cap2_edge)
        second_compare_value <= count;
      else if (xchg.req && xchg.sel == MFT_SEL_SECOND)
        second_compare_value <= xchg.wdata;
    end
  end

  // capture register is read-only to the cpu
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      capture_value <= MFT_COUNT_RESET;
    else if (cap1_edge)
      capture_value <= count;
  end

  // exchange returns the old contents of the selected register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      xchg_rdata <= '0;
    else if (xchg.req)
    begin
      unique case (xchg.sel)
        MFT_SEL_FIRST: xchg_rdata <= first_compare_value;
        MFT_SEL_SECOND: xchg_rdata <= second_compare_value;
        MFT_SEL_CAPTURE: xchg_rdata <= capture_value;
        default: xchg_rdata <= '0;
      endcase
    end
  end

  always_comb
  begin
    events = '0;
    events[MFT_PEND_OVF] = overflow;
    events[MFT_PEND_CMP1] = match && (capcmp || !phase_second);
    events[MFT_PEND_CMP2] = match && !capcmp && phase_second;
    events[MFT_PEND_CAP1] = cap1_edge;
    events[MFT_PEND_CAP2] = cap2_edge;
  end

  // sticky flags; a fresh event wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pending <= '0;
    else
      pending <= (pending & ~pend_clear) | events;
  end

  // per-source enables gate the request line
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= (cfg.overflow_irq_enable & pending[MFT_PEND_OVF])
           | (cfg.compare_irq_enable & (pending[MFT_PEND_CMP1] | pending[MFT_PEND_CMP2]))
           | (cfg.capture_irq_enable & (pending[MFT_PEND_CAP1] | pending[MFT_PEND_CAP2]));
  end
endmodule // mft_timer
`default_nettype wire

// ### mft_timer_assertions.sv
`default_nettype none
module mft_timer_chk
  import mft_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire mft_mode_e mode,
  input wire mft_cfg_s cfg,
  input wire mft_xchg_s xchg,
  input wire logic [MFT_PEND_W-1:0] pend_clear,
  input wire logic [15:0] xchg_rdata,
  input wire logic timer_out,
  input wire logic [MFT_PEND_W-1:0] pending,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic want;
  // request the irq register should follow, one cycle late
  assign want = (cfg.overflow_irq_enable & pending[0]) | (cfg.compare_irq_enable & (|pending[2:1]))
    | (cfg.capture_irq_enable & (|pending[4:3]));
  property p_hold; 1 |=> ($past(pending) & ~$past(pend_clear) & ~pending) == '0; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_irq; 1 |=> irq == $past(want); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_sel3; xchg.req && xchg.sel == 2'h3 |=> xchg_rdata == 16'h0000; endproperty
  a_sel3: assert property (p_sel3) else $error("bad select read");
  property p_rd; !xchg.req |=> $stable(xchg_rdata); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  property p_soft; $past(mode) == MFT_MODE_SOFT |-> $stable(timer_out); endproperty
  a_soft: assert property (p_soft) else $error("output moved");
  property p_tog; $past(mode) == MFT_MODE_PWM && $changed(timer_out) |-> ##[0:2] (|pending[2:1]); endproperty
  a_tog: assert property (p_tog) else $error("toggle without match");
  property p_cmp2;
    $rose(pending[2]) |-> $past(mode) != MFT_MODE_CAPCMP || $past(mode, 2) != MFT_MODE_CAPCMP;
  endproperty
  a_cmp2: assert property (p_cmp2) else $error("second match in capture mode");
  property p_cap; $rose(|pending[4:3]) |-> $past(mode) == MFT_MODE_CAPCMP || $past(mode, 2) == MFT_MODE_CAPCMP;
  endproperty
  a_cap: assert property (p_cap) else $error("capture outside capture mode");
  c_ovf: cover property ($rose(pending[0]));
  c_irq: cover property ($rose(irq));
  c_tog: cover property ($changed(timer_out));
endmodule // mft_timer_chk
bind mft_timer mft_timer_chk mft_timer_chk_inst (.clk, .rst, .mode, .cfg, .xchg, .pend_clear, .xchg_rdata,
  .timer_out, .pending, .irq);
`default_nettype wire

// ### mft_pin_model.sv
`default_nettype none
module mft_pin_model
(
  input wire logic clk,
  input wire logic run,
  input wire logic [1:0] cap_req,
  output logic ext_clk_pin,
  output logic capture1_pin,
  output logic capture2_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // event source stands still unless asked, as a real one may
  initial ext_clk_pin = 1'b0;
  always @(negedge clk)
  begin
    n <= run ? (n + 1) % 3 : 0;
    if (run && n == 2)
      ext_clk_pin <= ~ext_clk_pin;
    {capture2_pin, capture1_pin} <= cap_req;
  end
endmodule // mft_pin_model
`default_nettype wire

// ### tb_multi_function_timer_pwm.sv
`default_nettype none
module tb_multi_function_timer_pwm
  import mft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, run, timer_out, irq, ext_clk_pin, capture1_pin, capture2_pin;
  logic [1:0] cap_req;
  logic [3:0] div_sel;
  logic [15:0] xchg_rdata, a, b, q, q0;
  logic [MFT_PEND_W-1:0] pend_clear, pending;
  mft_mode_e mode;
  mft_cfg_s cfg;
  mft_xchg_s xchg;
  int err_count = 0;
  int samples_checked = 0;
  int d, n;
  mft_timer mft_timer_inst (.clk, .rst, .mode, .div_sel, .cfg, .ext_clk_pin, .capture1_pin, .capture2_pin,
    .xchg, .pend_clear, .xchg_rdata, .timer_out, .pending, .irq);
  mft_pin_model mft_pin_model_inst (.clk, .run, .cap_req, .ext_clk_pin, .capture1_pin, .capture2_pin);
  // system clock
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // exchange: new value goes in, old one comes back next cycle
  task automatic xg(input logic [1:0] s, input logic [15:0] w, output logic [15:0] r);
    @(negedge clk) xchg = '{1'b1, s, w};
    @(negedge clk) xchg.req = 1'b0;
    r = xchg_rdata;
  endtask
  // cycles to the next output change, bounded so a stuck output cannot hang
  task automatic tog(output int c);
    logic o;
    o = timer_out;
    c = 0;
    while (timer_out === o && c < 70000)
    begin
      @(negedge clk);
      c++;
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog, well past the overflow wait
  initial
  begin
    #2400000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'h6111_6a56));
    // every control starts idle; a stray all-ones clear would wipe the flags under test
    {run, cap_req, div_sel, cfg, xchg, pend_clear} = '0;
    rst = 1;
    mode = MFT_MODE_PWM;
    repeat (4) @(negedge clk);
    rst = 0;
    chk(pending, 0);
    chk(timer_out, 0);
    for (int s = 0; s < 4; s++)
    begin
      a = 16'($urandom);
      xg(2'(s), a, q0);
      xg(2'(s), ~a, q);
      chk(q, s < 2 ? a : (s == 3 ? 16'h0000 : q0));
    end
    cfg.compare_irq_enable = 1;
    repeat (3)
    begin
      a = 16'($urandom_range(12, 4));
      b = 16'($urandom_range(12, 4));
      d = $urandom_range(2, 0);
      div_sel = 4'(d);
      rst = 1;
      @(negedge clk) rst = 0;
      xg(MFT_SEL_FIRST, a, q);
      xg(MFT_SEL_SECOND, b, q);
      tog(n);
      tog(n);
      repeat (2)
      begin
        tog(n);
        chk(16'(n), 16'(((timer_out ? a : b) + 1) << d));
      end
      chk(pending[2:1], 3);
      chk(irq, 1);
    end
    cfg.compare_irq_enable = 0;
    mode = MFT_MODE_SOFT;
    @(negedge clk) q = timer_out;
    pend_clear = '1;
    @(negedge clk) pend_clear = '0;
    // both phases must end after the clear: up to two periods of 13 ticks of 4 clocks
    repeat (120) @(negedge clk);
    chk(timer_out, q);
    chk(pending[2:1], 3);
    chk(irq, 0);
    rst = 1;
    @(negedge clk) rst = 0;
    mode = MFT_MODE_EXT;
    cfg.ext_rising = 1;
    run = 1;
    xg(MFT_SEL_FIRST, 16'h0002, q);
    xg(MFT_SEL_SECOND, 16'h0002, q);
    repeat (80) @(negedge clk);
    run = 0;
    chk(pending[2:1], 3);
    mode = MFT_MODE_CAPCMP;
    div_sel = 0;
    cfg = 5'h0f;
    cap_req = 2'b11;
    repeat (2) @(negedge clk);
    cap_req = 0;
    repeat (8) @(negedge clk);
    chk(pending[4:3], 3);
    chk(irq, 1);
    n = 0;
    while (pending[0] !== 1'b1 && n < 70000)
    begin
      @(negedge clk);
      n++;
    end
    chk(pending[0], 1);
    report_and_stop();
  end
endmodule // tb_multi_function_timer_pwm
`default_nettype wire
